// file: pvpf_pkg.sv
// package for the pager vector packet formatter: field layout, codes, limits
`default_nettype none
package pvpf_pkg;
    // vector type codes (low three bits of byte 2)
    localparam logic [2:0] PVPF_VT_SHORT = 3'h2;
    localparam logic [2:0] PVPF_VT_SECURE = 3'h0;
    localparam logic [2:0] PVPF_VT_ALPHA = 3'h5;
    localparam logic [2:0] PVPF_VT_HEXBIN = 3'h6;
    // short message types
    localparam logic [1:0] PVPF_MT_NUMERIC = 2'h0;
    localparam logic [1:0] PVPF_MT_TONE8 = 2'h1;
    localparam logic [1:0] PVPF_MT_TONENUM = 2'h2;
    localparam logic [1:0] PVPF_MT_SPARE = 2'h3;
    // word position limits
    localparam logic [6:0] PVPF_INDEX_MIN = 7'h02;
    localparam logic [6:0] PVPF_INDEX_MAX = 7'h57;
    localparam logic [6:0] PVPF_START_MIN = 7'h03;
    localparam logic [6:0] PVPF_START_MAX = 7'h57;
    localparam logic [6:0] PVPF_COUNT_MIN = 7'h01;
    localparam logic [6:0] PVPF_COUNT_MAX = 7'h55;
    // field positions in the 32-bit packet, bit error limit, packet reset value
    localparam int PVPF_POS_INDEX = 24;
    localparam int PVPF_POS_ERR = 23;
    localparam int PVPF_POS_PHASE = 21;
    localparam int PVPF_POS_VT = 16;
    localparam int PVPF_POS_DATA = 2;
    localparam int PVPF_POS_COUNT = 7;
    localparam int PVPF_ERR_LIMIT = 2;
    localparam logic [31:0] PVPF_PKT_RESET = 32'h0000_0000;

    // decoded vector word handed in by the frame logic
    typedef struct packed {
        logic [6:0] word_pos;
        logic [1:0] phase;
        logic [2:0] vtype;
        logic [2:0] bit_errors;
        logic check_fail;
        logic value_bad;
        logic long_addr;
        logic network_addr;
        logic [1:0] msg_type;
        logic [11:0] short_data;
        logic [6:0] word_count;
        logic [6:0] start_word;
    } pvpf_vector_t;

    // message word handed in by the frame logic
    typedef struct packed {
        logic [6:0] word_pos;
        logic [1:0] phase;
        logic err;
        logic [20:0] info;
    } pvpf_msgword_t;
endpackage : pvpf_pkg
`default_nettype wire

// file: pvpf_field_pack.sv
// short message data field packer, chosen by message type and address kind
`default_nettype none
module pvpf_field_pack
    import pvpf_pkg::*;
(
    input wire logic [1:0] msg_type_in,
    input wire logic network_addr_in,
    input wire logic [11:0] raw_in,
    output logic [11:0] data_out
);
    // network id pieces, sources, retrieval flag and number keep raw order
    always_comb begin
        data_out = raw_in;
        unique case (msg_type_in)
            PVPF_MT_NUMERIC: begin
                // three numeric chars, or id split four/three/five bits
                data_out = network_addr_in ? {raw_in[11:8], raw_in[7:5], raw_in[4:0]}
                                           : {raw_in[11:8], raw_in[7:4], raw_in[3:0]};
            end
            PVPF_MT_TONE8: begin
                data_out = {raw_in[11:4], 4'h0};
            end
            PVPF_MT_TONENUM: begin
                data_out = {raw_in[11:10], raw_in[9], raw_in[8:3], 3'h0};
            end
            PVPF_MT_SPARE: begin
                data_out = raw_in;
            end
        endcase
    end
endmodule : pvpf_field_pack
`default_nettype wire

// file: pvpf_formatter.sv
// vector packet formatter top: builds vector and follow-on message packets
//
// Overview of operation
// - top bit zero, then seven-bit vector word position
// - short message vector type reads 010
// - short vector error on bit errors or check
// - phase field in byte 2 bits 6-5
// - twelve data bits plus two-bit message type
// - type 00 messaging: three numeric characters
// - type 00 network: identifier in 4/3/5 bits
// - type 01: eight tone sources, rest unused
// - type 10: sources, retrieval flag, message number
// - long address, no error: send next word
// - follow-on packet carries five more characters
// - secure 000, alphanumeric 101, hex 110
// - long vector error also on invalid value
// - seven-bit word count, valid 1 to 85
// - seven-bit start field, valid 3 to 87
// - long address first word follows vector
// - packet identifier equals vector word position
// - vector errors arm no follow-on word; an errored long vector also closes the message window
// - long vectors enter all-frame mode until disabled
////////////////////////////////////////////////////////////////////////////////
`default_nettype none
module pvpf_formatter
    import pvpf_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    input wire logic vector_valid_in,
    input wire pvpf_vector_t vector_in,
    input wire logic msgword_valid_in,
    input wire pvpf_msgword_t msgword_in,
    input wire logic allframe_clear_in,
    output logic packet_valid_out,
    output logic [31:0] packet_out,
    output logic packet_is_vector_out,
    output logic allframe_mode_out,
    output logic follow_expected_out
);
    ////////////////////////////////////////////////////////////////////////////
    // reset release through two flops
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // vector classification
    logic is_short;
    logic is_long;
    logic vec_err;
    logic count_bad;
    logic start_bad;
    logic index_bad;
    logic [11:0] short_field;

    assign is_short = (vector_in.vtype == PVPF_VT_SHORT);
    assign is_long = (vector_in.vtype == PVPF_VT_SECURE)
                  || (vector_in.vtype == PVPF_VT_ALPHA)
                  || (vector_in.vtype == PVPF_VT_HEXBIN);
    // word position outside the frame's vector span marks a long vector invalid
    assign index_bad = (vector_in.word_pos < PVPF_INDEX_MIN)
                    || (vector_in.word_pos > PVPF_INDEX_MAX);
    assign count_bad = (vector_in.word_count < PVPF_COUNT_MIN)
                    || (vector_in.word_count > PVPF_COUNT_MAX);
    assign start_bad = (vector_in.start_word < PVPF_START_MIN)
                    || (vector_in.start_word > PVPF_START_MAX);

    // invalid values only count against long-message vectors
    always_comb begin
        vec_err = (vector_in.bit_errors > 3'(PVPF_ERR_LIMIT)) || vector_in.check_fail;
        if (is_long) begin
            vec_err = vec_err || vector_in.value_bad || count_bad || start_bad || index_bad;
        end
    end

    pvpf_field_pack u_field_pack (
        .msg_type_in(vector_in.msg_type),
        .network_addr_in(vector_in.network_addr),
        .raw_in(vector_in.short_data),
        .data_out(short_field)
    );

    ////////////////////////////////////////////////////////////////////////////
    // packet word assembly
    logic [31:0] vec_word;
    logic [31:0] msg_word;
    always_comb begin
        vec_word = PVPF_PKT_RESET;
        vec_word[31] = 1'b0;
        vec_word[PVPF_POS_INDEX +: 7] = vector_in.word_pos;
        vec_word[PVPF_POS_ERR] = vec_err;
        vec_word[PVPF_POS_PHASE +: 2] = vector_in.phase;
        vec_word[PVPF_POS_VT +: 3] = vector_in.vtype;
        if (is_short) begin
            vec_word[PVPF_POS_DATA +: 12] = short_field;
            vec_word[1:0] = vector_in.msg_type;
        end else begin
            vec_word[PVPF_POS_COUNT +: 7] = vector_in.word_count;
            vec_word[6:0] = vector_in.start_word;
        end
    end

    // message word: same header layout, 21 info bits low
    always_comb begin
        msg_word = PVPF_PKT_RESET;
        msg_word[PVPF_POS_INDEX +: 7] = msgword_in.word_pos;
        msg_word[PVPF_POS_ERR] = msgword_in.err;
        msg_word[PVPF_POS_PHASE +: 2] = msgword_in.phase;
        msg_word[20:0] = msgword_in.info;
    end

    ////////////////////////////////////////////////////////////////////////////
    // follow-on tracking: the word right after a long-address vector
    logic follow_q;
    logic [6:0] follow_pos_q;
    logic [1:0] follow_phase_q;
    logic follow_hit;
    logic follow_arm;

    assign follow_arm = vector_valid_in && vector_in.long_addr && !vec_err
                     && (is_short || is_long);
    assign follow_hit = msgword_valid_in && follow_q
                     && (msgword_in.word_pos == follow_pos_q)
                     && (msgword_in.phase == follow_phase_q);

    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            follow_q <= 1'b0;
            follow_pos_q <= 7'h00;
            follow_phase_q <= 2'h0;
        end else if (follow_arm) begin
            follow_q <= 1'b1;
            follow_pos_q <= 7'(vector_in.word_pos + 7'h01);
            follow_phase_q <= vector_in.phase;
        end else if (follow_hit) begin
            follow_q <= 1'b0;
        end
    end

    // message words are passed only for the armed follow-on or a clean long vector window
    logic msg_open_q;
    logic [1:0] msg_phase_q;
    logic [6:0] msg_lo_q;
    logic [6:0] msg_hi_q;
    logic msg_in_window;

    assign msg_in_window = msg_open_q && (msgword_in.phase == msg_phase_q)
                        && (msgword_in.word_pos >= msg_lo_q)
                        && (msgword_in.word_pos <= msg_hi_q);

    // start field points at the second word when the first follows the vector
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            msg_open_q <= 1'b0;
            msg_phase_q <= 2'h0;
            msg_lo_q <= 7'h00;
            msg_hi_q <= 7'h00;
        end else if (vector_valid_in && is_long) begin
            msg_open_q <= !vec_err;
            msg_phase_q <= vector_in.phase;
            msg_lo_q <= vector_in.start_word;
            msg_hi_q <= 7'(vector_in.start_word + vector_in.word_count
                       - (vector_in.long_addr ? 7'h02 : 7'h01));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // all-frame mode: set wins over a clear in the same cycle
    logic allframe_q;
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            allframe_q <= 1'b0;
        end else if (vector_valid_in && is_long) begin
            allframe_q <= 1'b1;
        end else if (allframe_clear_in) begin
            allframe_q <= 1'b0;
        end
    end
    assign allframe_mode_out = allframe_q;
    assign follow_expected_out = follow_q;

    ////////////////////////////////////////////////////////////////////////////
    // output register: vector wins if both arrive; frame order makes that rare
    logic pkt_valid_q;
    logic [31:0] pkt_q;
    logic pkt_vec_q;
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pkt_valid_q <= 1'b0;
            pkt_q <= PVPF_PKT_RESET;
            pkt_vec_q <= 1'b0;
        end else if (vector_valid_in && (is_short || is_long)) begin
            pkt_valid_q <= 1'b1;
            pkt_q <= vec_word;
            pkt_vec_q <= 1'b1;
        end else if (msgword_valid_in && (follow_hit || msg_in_window)) begin
            pkt_valid_q <= 1'b1;
            pkt_q <= msg_word;
            pkt_vec_q <= 1'b0;
        end else begin
            pkt_valid_q <= 1'b0;
        end
    end
    assign packet_valid_out = pkt_valid_q;
    assign packet_out = pkt_q;
    assign packet_is_vector_out = pkt_vec_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_top_bit_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        packet_valid_out |-> !packet_out[31])
        else $error("packet top bit set");
    a_short_type: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && is_short |=> packet_out[18:16] == 3'h2)
        else $error("short vector type wrong");
    a_short_err: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && is_short && vector_in.bit_errors > 3'h2 |=> packet_out[23])
        else $error("short vector error flag missing");
    a_phase_copy: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && (is_short || is_long)
        |=> packet_out[22:21] == $past(vector_in.phase))
        else $error("phase field wrong");
    a_id_equals_index: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && is_long |=> packet_out[30:24] == $past(vector_in.word_pos))
        else $error("identifier mismatch");
    a_long_invalid: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && is_long && vector_in.value_bad |=> packet_out[23])
        else $error("invalid vector not flagged");
    a_allframe_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && is_long |=> allframe_mode_out)
        else $error("all-frame mode not entered");
    a_err_no_follow: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && vec_err && !follow_q |=> !follow_q)
        else $error("follow-on armed after error");
    a_follow_arm: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        follow_arm |=> follow_q && follow_pos_q == 7'($past(vector_in.word_pos) + 7'h01))
        else $error("follow-on not armed");
    // short vector: message type sits in the two lowest bits
    a_short_mtype: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && is_short |=> packet_out[1:0] == $past(vector_in.msg_type))
        else $error("short message type misplaced");
    // a failed check character alone must raise the flag
    a_short_check: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && is_short && vector_in.check_fail |=> packet_out[23])
        else $error("check failure not flagged");
    // long vector: count and start copied into the low fourteen bits
    a_long_fields: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && is_long |=> packet_out[13:7] == $past(vector_in.word_count)
            && packet_out[6:0] == $past(vector_in.start_word))
        else $error("count or start field wrong");
    // out-of-range count or start is an invalid value
    a_long_range: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && is_long
        && (vector_in.word_count > PVPF_COUNT_MAX || vector_in.start_word < PVPF_START_MIN)
        |=> packet_out[23])
        else $error("range error not flagged");
    // follow-on word goes out whole as a message packet
    a_follow_body: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        follow_hit && !vector_valid_in
        |=> packet_valid_out && !packet_is_vector_out
            && packet_out[20:0] == $past(msgword_in.info))
        else $error("follow-on message body lost");
    a_follow_id: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        follow_hit && !vector_valid_in |=> packet_out[30:24] == $past(follow_pos_q))
        else $error("follow-on word position wrong");
    // an invalid long vector must not leave a message window open
    a_err_closes: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && is_long && vector_in.value_bad |=> !msg_open_q)
        else $error("message window open after error");
    a_allframe_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        allframe_clear_in && !(vector_valid_in && is_long) |=> !allframe_mode_out)
        else $error("all-frame mode not cleared");
    // every accepted vector answers with exactly one vector packet next cycle
    a_vec_answer: assert property (@(posedge ref_clk_in) disable iff (!rst_n_q)
        vector_valid_in && (is_short || is_long) |=> packet_valid_out && packet_is_vector_out)
        else $error("vector packet not sent");
endmodule : pvpf_formatter
`default_nettype wire

// file: pvpf_host_model.sv
// host-side model: latches every packet and drops bits it may not rely on
`default_nettype none
module pvpf_host_model (
    input wire logic clk_in,
    input wire logic valid_in,
    input wire logic is_vector_in,
    input wire logic [31:0] packet_in,
    output logic [31:0] seen_out,
    output logic seen_vector_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // unused vector bits are zeroed, never trusted; message bits are kept
    // for all four short message types and the secure, alphanumeric and hex long vectors the bench drives
    always_ff @(posedge clk_in) begin
        if (valid_in) begin
            seen_out <= is_vector_in ? (packet_in & 32'hFFE7_3FFF) : packet_in;
            seen_vector_out <= is_vector_in;
        end
    end
endmodule : pvpf_host_model
`default_nettype wire

// file: test_pvpf_formatter.sv
// self-checking bench for the vector packet formatter
`default_nettype none
module test_pvpf_formatter;
    import pvpf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in, reset_n_in, vv, mv, afc, pv, isv, afm, fol, seen_v;
    pvpf_vector_t vec, v;
    pvpf_msgword_t msg, m;
    logic [31:0] pkt, seen;
    logic [2:0] lvt [3];
    int n_fail, n_tests, cyc;

    pvpf_formatter DUT (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .vector_valid_in(vv), .vector_in(vec), .msgword_valid_in(mv), .msgword_in(msg),
        .allframe_clear_in(afc), .packet_valid_out(pv), .packet_out(pkt),
        .packet_is_vector_out(isv), .allframe_mode_out(afm), .follow_expected_out(fol));
    pvpf_host_model host (.clk_in(ref_clk_in), .valid_in(pv), .is_vector_in(isv),
        .packet_in(pkt), .seen_out(seen), .seen_vector_out(seen_v));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; the whole run needs well under 400 cycles
    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    // one strobe cycle, then sample just after the answering edge
    task automatic pulse(input logic is_vec, input pvpf_vector_t a, input pvpf_msgword_t b);
        @(posedge ref_clk_in);
        vv <= is_vec;
        mv <= !is_vec;
        vec <= a;
        msg <= b;
        @(posedge ref_clk_in);
        vv <= 1'b0;
        mv <= 1'b0;
        #1;
    endtask : pulse
    // packet must appear one cycle after the strobe; host holds it a cycle later
    task automatic expect_pkt(input logic vld, input logic [31:0] p, input logic isv_e);
        check(32'(pv), 32'(vld));
        if (vld) begin
            @(posedge ref_clk_in);
            #1;
            check(seen, p);
            check(32'(seen_v), 32'(isv_e));
        end
    endtask : expect_pkt
    function automatic pvpf_vector_t mkv(input logic [6:0] wp, input logic [2:0] vt,
        input logic [2:0] be, input logic la, input logic na, input logic [1:0] mt,
        input logic [11:0] sd, input logic [6:0] wc, input logic [6:0] sw);
        return '{wp, wp[1:0], vt, be, 1'b0, 1'b0, la, na, mt, sd, wc, sw};
    endfunction : mkv
    // expected vector packet; unused tone bits and x bits read zero
    function automatic logic [31:0] vp(input pvpf_vector_t a, input logic e);
        logic [11:0] d;
        d = a.short_data;
        if (a.msg_type == PVPF_MT_TONE8) begin
            d[3:0] = 4'h0;
        end else if (a.msg_type == PVPF_MT_TONENUM) begin
            d[2:0] = 3'h0;
        end
        if (a.vtype == PVPF_VT_SHORT) begin
            return {1'b0, a.word_pos, e, a.phase, 2'b00, a.vtype, 2'b00, d, a.msg_type};
        end
        return {1'b0, a.word_pos, e, a.phase, 2'b00, a.vtype, 2'b00, a.word_count, a.start_word};
    endfunction : vp

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {vv, mv, afc} = 3'b000;
        vec = '0;
        msg = '0;
        lvt = '{PVPF_VT_SECURE, PVPF_VT_ALPHA, PVPF_VT_HEXBIN};
        reset_n_in = 1'b0;
        repeat (12) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        // short vectors: all four types, both address kinds, word positions 87 down to 2
        for (int i = 0; i < 8; i++) begin
            v = mkv(7'(i == 7 ? 2 : 87 - i * 12), PVPF_VT_SHORT,
                3'(i % 3), 1'b0, i[0], 2'(i / 2), 12'hA5F ^ 12'(i << 8), 7'h00, 7'h00);
            pulse(1'b1, v, '0);
            expect_pkt(1'b1, vp(v, 1'b0), 1'b1);
        end
        // a failed check character, then three bit errors
        for (int j = 0; j < 2; j++) begin
            v = mkv(7'h10, PVPF_VT_SHORT, j ? 3'd3 : 3'd2, 1'b0, 1'b0, 2'b00, 12'h123,
                7'h00, 7'h00);
            v.check_fail = !j;
            pulse(1'b1, v, '0);
            expect_pkt(1'b1, vp(v, 1'b1), 1'b1);
        end
        $display("short vector tests done");
        // long address: clean vector arms the follow-on word, errored one does not
        v = mkv(7'h20, PVPF_VT_SHORT, 3'd0, 1'b1, 1'b0, 2'b00, 12'h987, 7'h00, 7'h00);
        pulse(1'b1, v, '0);
        check(32'(fol), 32'h0000_0001);
        expect_pkt(1'b1, vp(v, 1'b0), 1'b1);
        // right word position on the wrong phase must not pair
        m = '{7'h21, v.phase + 2'h1, 1'b0, 21'h1A_BCDE};
        pulse(1'b0, '0, m);
        expect_pkt(1'b0, 32'h0000_0000, 1'b0);
        check(32'(fol), 32'h0000_0001);
        m = '{7'h21, v.phase, 1'b0, 21'h1A_BCDE};
        pulse(1'b0, '0, m);
        expect_pkt(1'b1, {1'b0, m.word_pos, m.err, m.phase, m.info}, 1'b0);
        v.bit_errors = 3'd3;
        pulse(1'b1, v, '0);
        check(32'(fol), 32'h0000_0000);
        expect_pkt(1'b1, vp(v, 1'b1), 1'b1);
        pulse(1'b0, '0, m);
        expect_pkt(1'b0, 32'h0000_0000, 1'b0);
        $display("follow-on tests done");
        // long vectors: every type code, count, start and position bounds, invalid value
        for (int k = 0; k < 5; k++) begin
            v = mkv(k == 4 ? 7'h58 : 7'(5 + k), lvt[k % 3], 3'd0, 1'b0, 1'b0, 2'b00, 12'h000,
                k == 0 ? PVPF_COUNT_MAX : (k == 1 ? 7'h01 : (k == 2 ? 7'h56 : 7'h10)),
                k == 1 ? 7'h57 : (k == 3 ? 7'h02 : 7'h03));
            v.value_bad = (k == 1);
            pulse(1'b1, v, '0);
            if (k == 0) begin
                check(32'(afm), 32'h0000_0001);
            end
            expect_pkt(1'b1, vp(v, k != 0), 1'b1);
        end
        // long address long vector: word after vector, then start..start+count-2
        v = mkv(7'h30, PVPF_VT_ALPHA, 3'd0, 1'b1, 1'b0, 2'b00, 12'h000, 7'h03, 7'h40);
        pulse(1'b1, v, '0);
        check(32'(fol), 32'h0000_0001);
        expect_pkt(1'b1, vp(v, 1'b0), 1'b1);
        for (int w = 0; w < 4; w++) begin
            m = '{w == 0 ? 7'h31 : 7'(7'h3F + w), v.phase, 1'b0, 21'(w * 21'h0_1111)};
            pulse(1'b0, '0, m);
            expect_pkt(w != 3, {1'b0, m.word_pos, m.err, m.phase, m.info}, 1'b0);
        end
        // clear held high while a long vector lands: the set must win
        @(posedge ref_clk_in);
        afc <= 1'b1;
        pulse(1'b1, v, '0);
        check(32'(afm), 32'h0000_0001);
        expect_pkt(1'b1, vp(v, 1'b0), 1'b1);
        @(posedge ref_clk_in);
        afc <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
        #1;
        check(32'(afm), 32'h0000_0000);
        $display("long vector tests done");
        tally_and_finish();
    end
endmodule : test_pvpf_formatter
`default_nettype wire
